// [core/memory_jtag_tap_port.sv]
// Boundary-scan test access port controller for the memory device
`default_nettype none
// Functional notes
// - Standard state machine, instructions and serial registers
// - Inputs on rising edge, outputs after falling
// - Undriven mode select reads as high
// - Undriven data input shifts in as high
// - State plus instruction choose the serial register
// - Data out driven only while shifting
// - Five high mode-select edges force reset state
// - No asynchronous test reset input exists
// - Power-up reset; idle while test clock stands
// - Unused port leaves memory operation untouched
// - Three-bit instruction, preset to identification read
// - Capture loads 01; new instruction at update
// - One-bit bypass in shift under bypass instruction
// - 32-bit identification captured, shifted out LSB first
module memory_jtag_tap_port #(
  // Identification value is arbitrary; bit zero must be one
  parameter logic [31:0] ID_VALUE = 32'h0ABC_D001
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic tck,
  input wire logic tms,
  input wire logic tms_driven,
  input wire logic tdi,
  input wire logic tdi_driven,
  output logic tdo_out,
  output logic tdo_oe
);

  if (ID_VALUE[0] != 1'h1)
  begin : g_bad_id
    $error("ID_VALUE must have bit zero set");
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling and test clock edge detection

  tap_pkg::tap_pins_s pins_raw;
  tap_pkg::tap_pins_s pins;
  logic [tap_pkg::PINS_W-1:0] pins_vec;
  logic tck_prev_q;
  logic tck_prev_d;
  logic tck_rise;
  logic tck_fall;
  logic tms_eff;
  logic tdi_eff;

  // All pins cross together so mode select lines up with its clock edge
  always_comb
  begin
    pins_raw.tck = tck;
    pins_raw.tms = tms;
    pins_raw.tms_drv = tms_driven;
    pins_raw.tdi = tdi;
    pins_raw.tdi_drv = tdi_driven;
  end

  tap_pin_sync #(
    .WIDTH(tap_pkg::PINS_W)
  ) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .async_in(pins_raw),
    .sync_out(pins_vec)
  );

  assign pins = tap_pkg::tap_pins_s'(pins_vec);

  // Edges come from the synchronised level only
  always_comb
  begin
    tck_prev_d = pins.tck;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tck_prev_q <= 1'h0;
    end
    else
    begin
      tck_prev_q <= tck_prev_d;
    end
  end

  assign tck_rise = pins.tck & ~tck_prev_q;
  assign tck_fall = ~pins.tck & tck_prev_q;

  // Floating pins behave as the internal pull-ups would make them
  assign tms_eff = pins.tms_drv ? pins.tms : tap_pkg::UNDRIVEN_LEVEL;
  assign tdi_eff = pins.tdi_drv ? pins.tdi : tap_pkg::UNDRIVEN_LEVEL;

  ////////////////////////////////////////////////////////////////////////////
  // Controller state machine

  tap_pkg::tap_state_e state_q;
  tap_pkg::tap_state_e state_d;

  // Advance once per rising test clock; a standing clock freezes everything
  always_comb
  begin
    state_d = state_q;
    if (tck_rise)
    begin
      state_d = tap_pkg::next_state(state_q, tms_eff);
    end
  end

  // Only the power-up reset is asynchronous; no test reset pin exists
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= tap_pkg::ST_TLR;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Count of consecutive high mode-select edges, for checking only
  logic [2:0] hi_cnt_q;
  logic [2:0] hi_cnt_d;

  always_comb
  begin
    hi_cnt_d = hi_cnt_q;
    if (tck_rise)
    begin
      if (!tms_eff)
      begin
        hi_cnt_d = 3'h0;
      end
      else if (hi_cnt_q != 3'(tap_pkg::RESET_TMS_EDGES))
      begin
        hi_cnt_d = hi_cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hi_cnt_q <= 3'h0;
    end
    else
    begin
      hi_cnt_q <= hi_cnt_d;
    end
  end

  tms_reset_a: assert property (
    hi_cnt_q == 3'(tap_pkg::RESET_TMS_EDGES) |-> state_q == tap_pkg::ST_TLR)
    else $error("five high mode-select edges did not reach reset state");

  state_still_a: assert property (
    !tck_rise |=> $stable(state_q))
    else $error("controller moved without a rising test clock");

  undriven_tms_a: assert property (
    tck_rise && !pins.tms_drv && state_q == tap_pkg::ST_RTI
    |=> state_q == tap_pkg::ST_SEL_DR)
    else $error("floating mode select not taken as high");

  ////////////////////////////////////////////////////////////////////////////
  // Instruction register

  logic [tap_pkg::IR_W-1:0] ir_sh_q;
  logic [tap_pkg::IR_W-1:0] ir_sh_d;
  logic [tap_pkg::IR_W-1:0] ir_q;
  logic [tap_pkg::IR_W-1:0] ir_d;

  // Shift stage moves on rising edges; the active copy changes only at update or in the reset state
  always_comb
  begin
    ir_sh_d = ir_sh_q;
    ir_d = ir_q;
    if (tck_rise && state_q == tap_pkg::ST_CAPTURE_IR)
    begin
      ir_sh_d = {tap_pkg::IR_CAPTURE_MSB, tap_pkg::IR_CAPTURE_LSBS};
    end
    else if (tck_rise && state_q == tap_pkg::ST_SHIFT_IR)
    begin
      ir_sh_d = {tdi_eff, ir_sh_q[tap_pkg::IR_W-1:1]};
    end
    if (state_q == tap_pkg::ST_TLR)
    begin
      ir_d = tap_pkg::INS_IDCODE;
    end
    else if (tck_fall && state_q == tap_pkg::ST_UPDATE_IR)
    begin
      ir_d = ir_sh_q;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ir_sh_q <= '0;
      ir_q <= tap_pkg::INS_IDCODE;
    end
    else
    begin
      ir_sh_q <= ir_sh_d;
      ir_q <= ir_d;
    end
  end

  ir_preset_a: assert property (
    state_q == tap_pkg::ST_TLR |=> ir_q == tap_pkg::INS_IDCODE)
    else $error("instruction not preset in reset state");

  ir_capture_a: assert property (
    tck_rise && state_q == tap_pkg::ST_CAPTURE_IR
    |=> ir_sh_q[1:0] == tap_pkg::IR_CAPTURE_LSBS)
    else $error("instruction capture pattern wrong");

  ir_update_only_a: assert property (
    !(tck_fall && state_q == tap_pkg::ST_UPDATE_IR) && state_q != tap_pkg::ST_TLR
    |=> $stable(ir_q))
    else $error("instruction changed outside update");

  ////////////////////////////////////////////////////////////////////////////
  // Data registers: bypass and identification

  logic bypass_q;
  logic bypass_d;
  logic sel_idcode;
  logic id_capture;
  logic id_shift;
  logic id_out;

  // Boundary cells are not modelled, so every non-identification
  // instruction routes data through the bypass bit
  assign sel_idcode = (ir_q == tap_pkg::INS_IDCODE);
  assign id_capture = tck_rise && state_q == tap_pkg::ST_CAPTURE_DR && sel_idcode;
  assign id_shift = tck_rise && state_q == tap_pkg::ST_SHIFT_DR && sel_idcode;

  always_comb
  begin
    bypass_d = bypass_q;
    if (tck_rise && state_q == tap_pkg::ST_CAPTURE_DR && !sel_idcode)
    begin
      bypass_d = tap_pkg::BYPASS_CAPTURE;
    end
    else if (tck_rise && state_q == tap_pkg::ST_SHIFT_DR && !sel_idcode)
    begin
      bypass_d = tdi_eff;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bypass_q <= 1'h0;
    end
    else
    begin
      bypass_q <= bypass_d;
    end
  end

  tap_dr_shift #(
    .WIDTH(tap_pkg::ID_W)
  ) u_id (
    .core_clk(core_clk),
    .resetn(resetn),
    .capture(id_capture),
    .shift(id_shift),
    .ser_in(tdi_eff),
    .par_in(ID_VALUE),
    .ser_out(id_out)
  );

  sequence bypass_shift_s;
    tck_rise && state_q == tap_pkg::ST_SHIFT_DR && ir_q == tap_pkg::INS_BYPASS;
  endsequence

  undriven_tdi_a: assert property (
    bypass_shift_s and !pins.tdi_drv |=> bypass_q)
    else $error("floating data input not shifted as high");

  bypass_path_a: assert property (
    bypass_shift_s |=> bypass_q == $past(tdi_eff))
    else $error("bypass bit did not take the data input");

  sequence id_captured_s;
    id_capture ##1 !tck_rise [*2];
  endsequence

  id_capture_a: assert property (
    id_captured_s |-> id_out == ID_VALUE[0])
    else $error("identification value not captured");

  ////////////////////////////////////////////////////////////////////////////
  // Serial output, updated on falling test clock

  logic tdo_q;
  logic tdo_d;
  logic oe_q;
  logic oe_d;
  logic sel_bit;
  logic shifting;

  assign shifting = (state_q == tap_pkg::ST_SHIFT_DR) || (state_q == tap_pkg::ST_SHIFT_IR);

  // Output end of whichever register stands between the pins
  always_comb
  begin
    sel_bit = bypass_q;
    if (state_q == tap_pkg::ST_SHIFT_IR)
    begin
      sel_bit = ir_sh_q[0];
    end
    else if (sel_idcode)
    begin
      sel_bit = id_out;
    end
  end

  // Nothing here reaches the memory array, so an idle port is harmless
  always_comb
  begin
    tdo_d = tdo_q;
    oe_d = oe_q;
    if (tck_fall)
    begin
      tdo_d = sel_bit;
      oe_d = shifting;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tdo_q <= 1'h0;
      oe_q <= 1'h0;
    end
    else
    begin
      tdo_q <= tdo_d;
      oe_q <= oe_d;
    end
  end

  assign tdo_out = tdo_q;
  assign tdo_oe = oe_q;

  out_on_fall_a: assert property (
    $changed(tdo_out) || $changed(tdo_oe) |-> $past(tck_fall))
    else $error("serial output changed without a falling test clock");

  oe_shift_a: assert property (
    tck_fall |=> tdo_oe == $past(shifting))
    else $error("output enable does not follow shift states");

  tdo_bypass_a: assert property (
    tck_fall && state_q == tap_pkg::ST_SHIFT_DR && ir_q == tap_pkg::INS_BYPASS
    |=> tdo_out == $past(bypass_q))
    else $error("serial output is not the bypass bit");

endmodule : memory_jtag_tap_port
`default_nettype wire

// [core/tap_pkg.sv]
// Shared constants, types and helpers of the test access port
`default_nettype none
package tap_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register widths and capture patterns
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int SYNC_STAGES = 2;
  localparam int RESET_TMS_EDGES = 5;
  localparam logic [1:0] IR_CAPTURE_LSBS = 2'h1;
  localparam logic IR_CAPTURE_MSB = 1'h0;
  localparam logic BYPASS_CAPTURE = 1'h0;
  localparam logic UNDRIVEN_LEVEL = 1'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction codes
  localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
  localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
  localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
  localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Controller states, one-hot
  typedef enum logic [15:0] {
    ST_TLR        = 16'h0001,
    ST_RTI        = 16'h0002,
    ST_SEL_DR     = 16'h0004,
    ST_CAPTURE_DR = 16'h0008,
    ST_SHIFT_DR   = 16'h0010,
    ST_EXIT1_DR   = 16'h0020,
    ST_PAUSE_DR   = 16'h0040,
    ST_EXIT2_DR   = 16'h0080,
    ST_UPDATE_DR  = 16'h0100,
    ST_SEL_IR     = 16'h0200,
    ST_CAPTURE_IR = 16'h0400,
    ST_SHIFT_IR   = 16'h0800,
    ST_EXIT1_IR   = 16'h1000,
    ST_PAUSE_IR   = 16'h2000,
    ST_EXIT2_IR   = 16'h4000,
    ST_UPDATE_IR  = 16'h8000
  } tap_state_e;

  // Pins as seen at the pads, with pad-level presence sense
  typedef struct packed {
    logic tck;
    logic tms;
    logic tms_drv;
    logic tdi;
    logic tdi_drv;
  } tap_pins_s;

  localparam int PINS_W = $bits(tap_pins_s);

  // Mode-select driven successor of a controller state
  function automatic tap_state_e next_state(input tap_state_e s, input logic tms);
    tap_state_e n;
    n = ST_TLR;
    case (s)
      ST_TLR:        n = tms ? ST_TLR : ST_RTI;
      ST_RTI:        n = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR:     n = tms ? ST_SEL_IR : ST_CAPTURE_DR;
      ST_CAPTURE_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR:   n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR:   n = tms ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR:   n = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR:   n = tms ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_UPDATE_DR:  n = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR:     n = tms ? ST_TLR : ST_CAPTURE_IR;
      ST_CAPTURE_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR:   n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR:   n = tms ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR:   n = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR:   n = tms ? ST_UPDATE_IR : ST_SHIFT_IR;
      ST_UPDATE_IR:  n = tms ? ST_SEL_DR : ST_RTI;
      default:       n = ST_TLR;
    endcase
    return n;
  endfunction : next_state

endpackage : tap_pkg
`default_nettype wire

// [core/tap_pin_sync.sv]
// Two-stage synchroniser for the test port pins
`default_nettype none
module tap_pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("tap_pin_sync needs WIDTH of at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // First stage is read only by the second
  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule : tap_pin_sync
`default_nettype wire

// [core/tap_dr_shift.sv]
// Serial data register with parallel capture, shifting toward bit zero
`default_nettype none
module tap_dr_shift #(
  parameter int WIDTH = 32
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic capture,
  input wire logic shift,
  input wire logic ser_in,
  input wire logic [WIDTH-1:0] par_in,
  output logic ser_out
);

  logic [WIDTH-1:0] sr_q;
  logic [WIDTH-1:0] sr_d;

  if (WIDTH < 2)
  begin : g_bad_width
    $error("tap_dr_shift needs WIDTH of at least two");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture wins over shift; both are single-cycle strobes from the controller
  always_comb
  begin
    sr_d = sr_q;
    if (capture)
    begin
      sr_d = par_in;
    end
    else if (shift)
    begin
      sr_d = {ser_in, sr_q[WIDTH-1:1]};
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sr_q <= '0;
    end
    else
    begin
      sr_q <= sr_d;
    end
  end

  // Least significant bit leaves first
  assign ser_out = sr_q[0];

endmodule : tap_dr_shift
`default_nettype wire

// [verification/jtag_host_model.sv]
// Board-side scan controller model that drives the test port pins
`default_nettype none
module jtag_host_model
(
  input wire logic core_clk,
  input wire logic tdo_wire,
  output var tap_pkg::tap_pins_s pins,
  output logic seen_stb,
  output logic seen_tdo
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // Test clock rests low outside frames
  initial
  begin
    pins = '0;
    seen_stb = 1'h0;
    seen_tdo = 1'h0;
  end

  // Hand the settled data-out level to the bench
  task automatic report();
    seen_tdo = tdo_wire;
    seen_stb = 1'h1;
    @(negedge core_clk);
    seen_stb = 1'h0;
  endtask : report

  // One 160 ns test clock period; an undriven pin shows a changing level,
  // so only the presence flag can make it read as high
  task automatic step(input logic m, input logic dm, input logic d, input logic dd);
    @(negedge core_clk);
    pins.tms = dm ? m : ~pins.tms;
    pins.tms_drv = dm;
    pins.tdi = dd ? d : ~pins.tdi;
    pins.tdi_drv = dd;
    repeat (7) @(negedge core_clk);
    pins.tck = 1'h1;
    repeat (16) @(negedge core_clk);
    pins.tck = 1'h0;
    repeat (7) @(negedge core_clk);
    report();
  endtask : step

  // Wiggle mode select and data in while the test clock stands still
  task automatic idle(input int n);
    repeat (n)
    begin
      @(negedge core_clk);
      pins.tms = ~pins.tms;
      pins.tdi = pins.tdi ^ pins.tms;
    end
    report();
  endtask : idle
endmodule : jtag_host_model
`default_nettype wire

// [verification/memory_jtag_tap_port_tb.sv]
// Self-checking bench for the test access port against a scan reference
`default_nettype none
module memory_jtag_tap_port_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // Identification value is arbitrary; bit zero set
  localparam logic [31:0] ID = 32'h1357_9BDF;
  // Successor state index per mode-select level, one nibble per state
  localparam logic [63:0] NXT0 = 64'h1BDD_BBA1_4664_4311;
  localparam logic [63:0] NXT1 = 64'h2FEF_CC02_8785_5920;
  // Instructions loaded in turn, first one in the low bits
  localparam logic [17:0] INS_LIST = {3'h7, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
  logic core_clk = 1'h0;
  logic resetn = 1'h0;
  tap_pkg::tap_pins_s pins;
  logic tdo_out;
  logic tdo_oe;
  logic seen_stb;
  logic seen_tdo;
  wire logic tdo_wire;
  int n_mismatch = 0;
  int cmp_count = 0;
  int seed = 32'he77541a9;
  logic expq[$];
  logic [3:0] sx = 4'h0;
  logic [2:0] ir = tap_pkg::INS_IDCODE;
  logic [2:0] ir_sh = 3'h0;
  logic [31:0] sh = 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, pad resolution and instances
  always #2.5 core_clk = ~core_clk;
  assign tdo_wire = tdo_oe ? tdo_out : 1'hz;

  memory_jtag_tap_port #(.ID_VALUE(ID)) DUT (
    .core_clk(core_clk), .resetn(resetn), .tck(pins.tck), .tms(pins.tms),
    .tms_driven(pins.tms_drv), .tdi(pins.tdi), .tdi_driven(pins.tdi_drv),
    .tdo_out(tdo_out), .tdo_oe(tdo_oe));

  jtag_host_model host (.core_clk(core_clk), .tdo_wire(tdo_wire), .pins(pins),
    .seen_stb(seen_stb), .seen_tdo(seen_tdo));

  ////////////////////////////////////////////////////////////////////////////
  // Comparison and closing
  task automatic chk(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  // Oldest note against each reported data-out level; z means not driven
  always @(posedge seen_stb)
  begin
    // Let the reported level settle through the port before reading it
    #1;
    if (expq.size() == 0)
      chk("unexpected tdo", 1'h0, 1'h1);
    else
      chk("tdo", expq.pop_front(), seen_tdo);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference: work on the rise, state move, then note what the fall shows
  task automatic tck_step(input logic m, input logic dm, input logic d, input logic dd);
    logic em;
    logic ed;
    em = dm ? m : 1'h1;
    ed = dd ? d : 1'h1;
    case (sx)
      4'h3: sh = (ir == tap_pkg::INS_IDCODE) ? ID : 32'h0;
      4'h4: sh = (ir == tap_pkg::INS_IDCODE) ? {ed, sh[31:1]} : {31'h0, ed};
      4'hA: ir_sh = {tap_pkg::IR_CAPTURE_MSB, tap_pkg::IR_CAPTURE_LSBS};
      4'hB: ir_sh = {ed, ir_sh[2:1]};
      default: ;
    endcase
    sx = em ? NXT1[sx*4 +: 4] : NXT0[sx*4 +: 4];
    if (sx == 4'hF)
      ir = ir_sh;
    if (sx == 4'h0)
      ir = tap_pkg::INS_IDCODE;
    expq.push_back(sx == 4'h4 ? sh[0] : (sx == 4'hB ? ir_sh[0] : 1'hz));
    host.step(m, dm, d, dd);
  endtask : tck_step

  // Driven pins; bit i of each word is used on the i-th rise
  task automatic walk(input logic [63:0] t, input logic [63:0] di, input int n);
    for (int i = 0; i < n; i++)
      tck_step(t[i], 1'h1, di[i], 1'h1);
  endtask : walk

  task automatic id_read();
    walk(64'h0000_0030_0000_0002, {$random(seed), $random(seed)}, 39);
  endtask : id_read

  task automatic idle_check();
    expq.push_back(1'hz);
    host.idle(200);
  endtask : idle_check

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (20) @(negedge core_clk);
    resetn = 1'h1;
    idle_check();
    $display("test idle done");
    id_read();
    $display("test id done");
    for (int k = 0; k < 6; k++)
    begin
      walk(64'hC3, {57'h0, INS_LIST[k*3 +: 3], 4'h0}, 9);
      walk(64'hC01, {$random(seed), $random(seed)}, 13);
    end
    $display("test instructions done");
    walk(64'h1, 64'h0, 4);
    repeat (5)
      tck_step(1'h0, 1'h0, 1'h0, 1'h0);
    id_read();
    $display("test mode reset done");
    repeat (600)
      tck_step($random(seed), ($random(seed) & 3) != 0, $random(seed), $random(seed) & 1);
    $display("test random done");
    @(negedge core_clk);
    resetn = 1'h0;
    repeat (4) @(negedge core_clk);
    resetn = 1'h1;
    sx = 4'h0;
    ir = tap_pkg::INS_IDCODE;
    idle_check();
    id_read();
    $display("test power reset done");
    repeat (40) @(negedge core_clk);
    chk("pending notes", 1'h1, expq.size() == 0);
    wrap_up();
  end

  // Watchdog well beyond the expected run of about 140 us
  initial
  begin
    #400us;
    n_mismatch++;
    wrap_up();
  end
endmodule : memory_jtag_tap_port_tb
`default_nettype wire
